// File: logic/blk_pkg.sv
// constants, codes and types shared by the legacy block request parser
// assumes a single clock domain; the register offsets are byte addresses
package blk_pkg;
  // request type codes and the barrier flag position
  localparam logic [31:0] TYPE_READ = 32'h0000_0000;
  localparam logic [31:0] TYPE_WRITE = 32'h0000_0001;
  localparam logic [31:0] TYPE_SCSI = 32'h0000_0002;
  localparam logic [31:0] TYPE_SCSI_OUT = 32'h0000_0003;
  localparam logic [31:0] TYPE_FLUSH = 32'h0000_0004;
  localparam logic [31:0] TYPE_FLUSH_OLD = 32'h0000_0005;
  localparam int BARRIER_BIT = 31;
  // completion status byte codes
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_IOERR = 8'h01;
  localparam logic [7:0] ST_UNSUPP = 8'h02;
  // descriptor framing sizes in bytes
  localparam logic [31:0] HDR_DESC_BYTES = 32'h0000_0008;
  localparam logic [31:0] STATUS_DESC_BYTES = 32'h0000_0001;
  localparam logic [31:0] SENSE_BYTES = 32'h0000_0060;
  localparam logic [31:0] INFO_DESC_BYTES = 32'h0000_0010;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_CLEAR = 8'h08;
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h0c;
  localparam logic [7:0] REG_INFLIGHT = 8'h10;
  // control bits and event bits
  localparam int CTRL_BE_BIT = 0;
  localparam int CTRL_BARRIER_BIT = 1;
  localparam int CTRL_SCSI_BIT = 2;
  localparam int EV_DONE = 0;
  localparam int EV_UNSUPP = 1;
  localparam int EV_IOERR = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [2:0] IRQ_EN_RESET = 3'h0;
  typedef enum logic [2:0] {OP_READ, OP_WRITE, OP_FLUSH, OP_SCSI, OP_NONE} op_t;
  typedef enum logic [1:0] {S_IDLE, S_DESC, S_ISSUE, S_LOCAL} req_state_t;
endpackage : blk_pkg

// File: logic/hdr_decode.sv
// header decoder: byte order correction and type decoding, purely combinational
// assumes the raw words are the header bytes loaded in little-endian order
module hdr_decode (
  input wire logic [31:0] raw_type,
  input wire logic [31:0] raw_prio,
  input wire logic [63:0] raw_sector,
  input wire logic guest_be,
  input wire logic barrier_offered,
  input wire logic scsi_offered,
  output blk_pkg::op_t op,
  output logic [31:0] type_word,
  output logic barrier,
  output logic [31:0] prio,
  output logic [63:0] sector
);
  import blk_pkg::*;

  function automatic logic [31:0] bswap32(input logic [31:0] w);
    bswap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction : bswap32

  logic [31:0] base;

  always_comb begin
    type_word = guest_be ? bswap32(raw_type) : raw_type;
    prio = guest_be ? bswap32(raw_prio) : raw_prio;
    sector = guest_be ? {bswap32(raw_sector[31:0]), bswap32(raw_sector[63:32])} : raw_sector;
  end

  // barrier only when offered; otherwise the high bit makes the code unknown
  always_comb begin
    barrier = barrier_offered && type_word[BARRIER_BIT];
    base = barrier ? {1'b0, type_word[30:0]} : type_word;
  end

  // type decode, alias and scsi pair included
  always_comb begin
    case (base)
      TYPE_READ: op = OP_READ;
      TYPE_WRITE: op = OP_WRITE;
      // old flush alias decoded as flush
      TYPE_FLUSH, TYPE_FLUSH_OLD: op = OP_FLUSH;
      TYPE_SCSI, TYPE_SCSI_OUT: op = scsi_offered ? OP_SCSI : OP_NONE;
      default: op = OP_NONE;
    endcase
  end
endmodule : hdr_decode

// File: logic/blk_req_parser.sv
// legacy block request parser: header decode, descriptor framing check,
// backend issue with barrier ordering, completion fields and interrupt
// assumes one clock, a descriptor walker feeding one descriptor at a time,
// and a backend that echoes the tag it was given on each completion
//
// Functional notes
// - header fields are in guest native byte order, swapped when guest is big endian
// - second header word passes to backend as priority, larger is more important
// - offered barrier waits for all earlier, blocks later requests until done
// - barrier never flushes; only a flush request is issued as flush
// - scsi types 2 and 3 accepted and handled identically
// - scsi command sits in one readable descriptor; its length is the command length
// - header and command readable; direction and size come from data descriptors
// - sense length reports bytes written, at most 96
// - residual is requested length minus bytes transferred
// - every request ends with status 0 ok, 1 error, 2 unsupported
// - type 0 read, 1 write, 4 flush
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
module blk_req_parser #(
  parameter int TW = 2
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [31:0] req_type,
  input wire logic [31:0] req_prio,
  input wire logic [63:0] req_sector,
  input wire logic desc_valid,
  output logic desc_ready,
  input wire logic [31:0] desc_len,
  input wire logic desc_wr,
  input wire logic desc_last,
  output logic cmd_valid,
  input wire logic cmd_ready,
  output blk_pkg::op_t cmd_op,
  output logic [TW-1:0] cmd_tag,
  output logic [63:0] cmd_sector,
  output logic [31:0] cmd_prio,
  output logic [31:0] cmd_len,
  output logic [31:0] cmd_cdb_len,
  output logic cmd_dir_in,
  input wire logic done_valid,
  input wire logic [TW-1:0] done_tag,
  input wire logic done_err,
  input wire logic [31:0] done_xfer,
  input wire logic [7:0] done_sense_len,
  output logic cpl_valid,
  output logic [7:0] cpl_status,
  output logic cpl_scsi,
  output logic [31:0] cpl_residual,
  output logic [7:0] cpl_sense_len,
  output logic [31:0] cpl_data_len
);
  import blk_pkg::*;
  localparam int NTAG = 2 ** TW;

  typedef struct packed {
    req_state_t st;
    op_t op;
    logic barrier;
    logic bad;
    logic [31:0] prio;
    logic [63:0] sector;
    logic [7:0] dcnt;
    logic [31:0] data_len;
    logic [31:0] cdb_len;
    logic dir_in;
    logic [1:0] pcnt;
    logic [31:0] p0_len;
    logic p0_wr;
    logic [31:0] p1_len;
    logic p1_wr;
    logic [NTAG-1:0] busy;
    logic [NTAG-1:0] bar_tag;
    logic [NTAG-1:0] scsi_tag;
    logic [NTAG-1:0][31:0] tag_len;
    logic cpl_valid;
    logic [7:0] cpl_status;
    logic cpl_scsi;
    logic [31:0] cpl_residual;
    logic [7:0] cpl_sense_len;
    logic [31:0] cpl_data_len;
    logic [2:0] ctrl;
    logic [2:0] irq_st;
    logic [2:0] irq_en;
    logic [31:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic [TW:0] popcount(input logic [NTAG-1:0] v);
    logic [TW:0] c;
    c = '0;
    for (int i = 0; i < NTAG; i++) begin
      c = c + {{TW{1'b0}}, v[i]};
    end
    popcount = c;
  endfunction : popcount

  function automatic logic [TW-1:0] first_free(input logic [NTAG-1:0] v);
    logic [TW-1:0] t;
    t = '0;
    for (int i = NTAG - 1; i >= 0; i--) begin
      if (!v[i]) t = TW'(i);
    end
    first_free = t;
  endfunction : first_free

  op_t dec_op;
  logic [31:0] dec_type;
  logic dec_barrier;
  logic [31:0] dec_prio;
  logic [63:0] dec_sector;

  hdr_decode i_hdr_decode (.raw_type(req_type), .raw_prio(req_prio), .raw_sector(req_sector),
    .guest_be(s_q.ctrl[CTRL_BE_BIT]), .barrier_offered(s_q.ctrl[CTRL_BARRIER_BIT]),
    .scsi_offered(s_q.ctrl[CTRL_SCSI_BIT]), .op(dec_op), .type_word(dec_type), .barrier(dec_barrier),
    .prio(dec_prio), .sector(dec_sector));

  logic [TW:0] inflight;
  logic bar_hold;
  logic cmd_fire;
  logic is_scsi;

  // handshakes; a barrier drains the backend before it goes, and holds back later ones
  assign inflight = popcount(s_q.busy);
  assign bar_hold = |s_q.bar_tag;
  assign is_scsi = s_q.op == OP_SCSI;
  assign req_ready = s_q.st == S_IDLE;
  assign desc_ready = s_q.st == S_DESC;
  assign cmd_valid = s_q.st == S_ISSUE && !(&s_q.busy) && !bar_hold && (!s_q.barrier || inflight == '0);
  assign cmd_fire = cmd_valid && cmd_ready;

  // backend command fields come from the captured request; the tag is the lowest free one
  assign cmd_tag = first_free(s_q.busy);
  // barrier keeps its own op; no flush is invented for it
  assign cmd_op = s_q.op;
  assign cmd_sector = s_q.sector;
  assign cmd_prio = s_q.prio;
  assign cmd_len = s_q.data_len;
  assign cmd_cdb_len = s_q.cdb_len;
  assign cmd_dir_in = is_scsi ? s_q.dir_in : s_q.op == OP_READ;

  assign reg_rdata = s_q.rdata;
  assign irq = |(s_q.irq_st & s_q.irq_en);
  assign cpl_valid = s_q.cpl_valid;
  assign cpl_status = s_q.cpl_status;
  assign cpl_scsi = s_q.cpl_scsi;
  assign cpl_residual = s_q.cpl_residual;
  assign cpl_sense_len = s_q.cpl_sense_len;
  assign cpl_data_len = s_q.cpl_data_len;

  // whole next state; register writes first so hardware events win over a clear
  always_comb begin
    s_d = s_q;
    s_d.cpl_valid = 1'b0;
    s_d.rdata = 32'h0000_0000;
    if (reg_wr) begin
      unique case (reg_addr)
        REG_CTRL: s_d.ctrl = reg_wdata[2:0];
        REG_IRQ_CLEAR: s_d.irq_st = s_q.irq_st & ~reg_wdata[2:0];
        REG_IRQ_ENABLE: s_d.irq_en = reg_wdata[2:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL: s_d.rdata = {29'h0, s_q.ctrl};
        REG_IRQ_STATUS: s_d.rdata = {29'h0, s_q.irq_st};
        REG_IRQ_ENABLE: s_d.rdata = {29'h0, s_q.irq_en};
        REG_INFLIGHT: s_d.rdata = {{(31 - TW){1'b0}}, inflight};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    unique case (s_q.st)
      S_IDLE: begin
        if (req_valid) begin
          s_d.st = S_DESC;
          s_d.op = dec_op;
          s_d.barrier = dec_barrier;
          s_d.prio = dec_prio;
          s_d.sector = dec_sector;
          s_d.bad = 1'b0;
          s_d.dcnt = 8'h00;
          s_d.data_len = 32'h0000_0000;
          s_d.cdb_len = 32'h0000_0000;
          s_d.dir_in = 1'b0;
          s_d.pcnt = 2'd0;
        end
      end
      S_DESC: begin
        if (desc_valid) begin
          s_d.dcnt = s_q.dcnt + 8'h01;
          if (s_q.dcnt == 8'h00) begin
            // header descriptor readable and of fixed size
            if (desc_wr || desc_len != HDR_DESC_BYTES || desc_last) s_d.bad = 1'b1;
          end else if (is_scsi && s_q.dcnt == 8'h01) begin
            // command length from its own descriptor
            if (desc_wr || desc_len == 32'h0000_0000 || desc_last) s_d.bad = 1'b1;
            s_d.cdb_len = desc_len;
          end else if (desc_last) begin
            // status descriptor is one writable byte
            if (!desc_wr || desc_len != STATUS_DESC_BYTES) s_d.bad = 1'b1;
            if (is_scsi) begin
              // sense and info descriptors precede status
              if (s_q.pcnt != 2'd2 || !s_q.p0_wr || s_q.p0_len != SENSE_BYTES ||
                  !s_q.p1_wr || s_q.p1_len != INFO_DESC_BYTES) s_d.bad = 1'b1;
            end else begin
              if (s_q.pcnt != 2'd0) s_d.data_len = s_d.data_len + s_q.p0_len;
              if (s_q.pcnt == 2'd2) s_d.data_len = s_d.data_len + s_q.p1_len;
            end
          end else begin
            // data direction must match the request
            if (!is_scsi && s_q.op != OP_FLUSH && desc_wr != (s_q.op == OP_READ)) s_d.bad = 1'b1;
            // two-deep hold: the last two before status may be sense and info
            if (s_q.pcnt == 2'd2) begin
              // size and direction from the data buffers
              s_d.data_len = s_q.data_len + s_q.p0_len;
              s_d.dir_in = s_q.p0_wr;
              s_d.p0_len = s_q.p1_len;
              s_d.p0_wr = s_q.p1_wr;
              s_d.p1_len = desc_len;
              s_d.p1_wr = desc_wr;
            end else if (s_q.pcnt == 2'd1) begin
              s_d.p1_len = desc_len;
              s_d.p1_wr = desc_wr;
              s_d.pcnt = 2'd2;
            end else begin
              s_d.p0_len = desc_len;
              s_d.p0_wr = desc_wr;
              s_d.pcnt = 2'd1;
            end
          end
          if (desc_last) s_d.st = (s_q.op == OP_NONE || s_d.bad) ? S_LOCAL : S_ISSUE;
        end
      end
      S_ISSUE: begin
        if (cmd_fire) begin
          s_d.busy[cmd_tag] = 1'b1;
          s_d.bar_tag[cmd_tag] = s_q.barrier;
          s_d.scsi_tag[cmd_tag] = is_scsi;
          s_d.tag_len[cmd_tag] = s_q.data_len;
          s_d.st = S_IDLE;
        end
      end
      S_LOCAL: begin
        // backend completions take the output first; a local one waits for a cycle without done_valid
        if (!done_valid) begin
          s_d.cpl_valid = 1'b1;
          s_d.cpl_scsi = 1'b0;
          s_d.cpl_residual = 32'h0000_0000;
          s_d.cpl_sense_len = 8'h00;
          s_d.cpl_data_len = 32'h0000_0000;
          s_d.irq_st[EV_DONE] = 1'b1;
          if (s_q.op == OP_NONE) begin
            s_d.cpl_status = ST_UNSUPP;
            s_d.irq_st[EV_UNSUPP] = 1'b1;
          end else begin
            s_d.cpl_status = ST_IOERR;
            s_d.irq_st[EV_IOERR] = 1'b1;
          end
          s_d.st = S_IDLE;
        end
      end
    endcase
    if (done_valid) begin
      s_d.busy[done_tag] = 1'b0;
      s_d.bar_tag[done_tag] = 1'b0;
      s_d.cpl_valid = 1'b1;
      s_d.cpl_status = done_err ? ST_IOERR : ST_OK;
      s_d.cpl_scsi = s_q.scsi_tag[done_tag];
      // residual from requested and moved bytes
      s_d.cpl_residual = s_q.scsi_tag[done_tag] ? s_q.tag_len[done_tag] - done_xfer : 32'h0000_0000;
      // sense length capped to the sense buffer
      s_d.cpl_sense_len = !s_q.scsi_tag[done_tag] ? 8'h00 :
                          ({24'h0, done_sense_len} > SENSE_BYTES) ? SENSE_BYTES[7:0] : done_sense_len;
      // historic copy of the requested length
      s_d.cpl_data_len = s_q.scsi_tag[done_tag] ? s_q.tag_len[done_tag] : 32'h0000_0000;
      s_d.irq_st[EV_DONE] = 1'b1;
      if (done_err) s_d.irq_st[EV_IOERR] = 1'b1;
    end
  end

  // state register; constants only under reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{st: S_IDLE, op: OP_NONE, ctrl: CTRL_RESET, irq_en: IRQ_EN_RESET, default: '0};
    end else begin
      s_q <= s_d;
    end
  end
  logic [31:0] resid_want;
  assign resid_want = s_q.tag_len[done_tag] - done_xfer; // residual owed by the completing tag
  a_barrier_drain: assert property (@(posedge clock) disable iff (!rstn)
    cmd_fire && s_q.barrier |-> inflight == '0) else $error("barrier issued with requests in flight");
  a_barrier_block: assert property (@(posedge clock) disable iff (!rstn)
    bar_hold |-> !cmd_fire) else $error("request issued behind an open barrier");
  a_scsi_equal: assert property (@(posedge clock) disable iff (!rstn)
    (dec_type == TYPE_SCSI || dec_type == TYPE_SCSI_OUT) && s_q.ctrl[CTRL_SCSI_BIT] |-> dec_op == OP_SCSI)
    else $error("scsi type not decoded as scsi");
  a_type_decode: assert property (@(posedge clock) disable iff (!rstn)
    (dec_type == TYPE_FLUSH || dec_type == TYPE_FLUSH_OLD) |-> dec_op == OP_FLUSH)
    else $error("flush code not decoded as flush");
  a_residual_calc: assert property (@(posedge clock) disable iff (!rstn)
    done_valid && s_q.scsi_tag[done_tag] |=> cpl_valid && cpl_residual == $past(resid_want))
    else $error("residual mismatch");
  a_sense_cap: assert property (@(posedge clock) disable iff (!rstn)
    cpl_valid |-> {24'h0, cpl_sense_len} <= SENSE_BYTES) else $error("sense length above buffer");
  a_unsupp_local: assert property (@(posedge clock) disable iff (!rstn)
    s_q.st == S_LOCAL && s_q.op == OP_NONE && !done_valid |=> cpl_valid && cpl_status == ST_UNSUPP && !cmd_valid)
    else $error("unsupported request not completed as unsupported");
  a_status_code: assert property (@(posedge clock) disable iff (!rstn)
    done_valid |=> cpl_valid && cpl_status == ($past(done_err) ? ST_IOERR : ST_OK)) else $error("bad status byte");
  a_cmd_stable: assert property (@(posedge clock) disable iff (!rstn)
    cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_prio) && $stable(cmd_len))
    else $error("command changed while waiting");
  a_header_frame: assert property (@(posedge clock) disable iff (!rstn)
    s_q.st == S_DESC && desc_valid && s_q.dcnt == 8'h00 && desc_len != HDR_DESC_BYTES |=> s_q.bad || s_q.st == S_LOCAL)
    else $error("bad header descriptor accepted");
endmodule : blk_req_parser

// File: sim/guest_driver_model.sv
// guest driver model: posts a request header and its descriptor chain
// assumes the parser shares the clock and samples handshakes on rising edges
module guest_driver_model
  import blk_pkg::*;
(
  input wire logic clock,
  input wire logic req_ready,
  input wire logic desc_ready,
  output logic req_valid,
  output logic [31:0] req_type,
  output logic [31:0] req_prio,
  output logic [63:0] req_sector,
  output logic desc_valid,
  output logic [31:0] desc_len,
  output logic desc_wr,
  output logic desc_last
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle at time zero, nothing offered
  initial begin
    req_valid = 1'b0;
    req_type = 32'h0;
    req_prio = 32'h0;
    req_sector = 64'h0;
    desc_valid = 1'b0;
    desc_len = 32'h0;
    desc_wr = 1'b0;
    desc_last = 1'b0;
  end

  // one descriptor; valid stays up between descriptors, fields flip on release
  task automatic desc(input logic [31:0] len, input logic wr, input logic last);
    int n;
    n = 0;
    desc_valid <= 1'b1;
    desc_len <= len;
    desc_wr <= wr;
    desc_last <= last;
    @(posedge clock);
    while (desc_ready !== 1'b1 && n < 50) begin
      @(posedge clock);
      n++;
    end
    if (last) begin
      desc_valid <= 1'b0;
      desc_len <= ~len;
      desc_wr <= ~wr;
    end
  endtask : desc

  // used length and data length are never read back here
  // header in native order, data, then a one-byte status
  // scsi: one command buffer, a 96-byte sense, one info block
  task automatic post(input logic [31:0] t, input logic [31:0] p, input logic [63:0] s, input logic [31:0] hlen,
                      input logic [31:0] dlen, input logic dwr, input logic scsi, input logic [31:0] cdb);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_type <= t;
    req_prio <= p;
    req_sector <= s;
    @(posedge clock);
    while (req_ready !== 1'b1 && n < 50) begin
      @(posedge clock);
      n++;
    end
    req_valid <= 1'b0;
    req_type <= ~t;
    req_prio <= ~p;
    req_sector <= ~s;
    desc(hlen, 1'b0, 1'b0);
    if (scsi) desc(cdb, 1'b0, 1'b0);
    if (dlen != 32'h0) desc(dlen, dwr, 1'b0);
    if (scsi) begin
      desc(SENSE_BYTES, 1'b1, 1'b0);
      desc(INFO_DESC_BYTES, 1'b1, 1'b0);
    end
    desc(STATUS_DESC_BYTES, 1'b1, 1'b1);
  endtask : post
endmodule : guest_driver_model

// File: sim/tb_blk_req_parser.sv
// bench for the legacy block request parser: registers, request path, completions
// assumes the guest driver model on the request side; the bench acts as backend
module tb_blk_req_parser;
  timeunit 1ns;
  timeprecision 1ps;
  import blk_pkg::*;
  localparam int TW = 2;
  logic clock, rstn, reg_wr, reg_rd, irq, req_valid, req_ready, desc_valid, desc_ready, desc_wr, desc_last;
  logic cmd_valid, cmd_ready, cmd_dir_in, done_valid, done_err, cpl_valid, cpl_scsi, c_dir;
  logic [7:0] reg_addr, done_sense_len, cpl_status, cpl_sense_len;
  logic [31:0] reg_wdata, reg_rdata, req_type, req_prio, desc_len, cmd_prio, cmd_len, cmd_cdb_len, done_xfer;
  logic [31:0] cpl_residual, cpl_data_len, c_prio, c_len, c_cdb;
  logic [63:0] req_sector, cmd_sector, c_sector;
  logic [TW-1:0] cmd_tag, done_tag, c_tag, t_a;
  op_t cmd_op, c_op;
  int cmd_count = 0, errors = 0, checks_done = 0;

  blk_req_parser #(.TW(TW)) i_blk_req_parser (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .req_valid(req_valid), .req_ready(req_ready), .req_type(req_type), .req_prio(req_prio),
    .req_sector(req_sector), .desc_valid(desc_valid), .desc_ready(desc_ready), .desc_len(desc_len),
    .desc_wr(desc_wr), .desc_last(desc_last), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_tag(cmd_tag), .cmd_sector(cmd_sector), .cmd_prio(cmd_prio), .cmd_len(cmd_len),
    .cmd_cdb_len(cmd_cdb_len), .cmd_dir_in(cmd_dir_in), .done_valid(done_valid), .done_tag(done_tag),
    .done_err(done_err), .done_xfer(done_xfer), .done_sense_len(done_sense_len), .cpl_valid(cpl_valid),
    .cpl_status(cpl_status), .cpl_scsi(cpl_scsi), .cpl_residual(cpl_residual), .cpl_sense_len(cpl_sense_len),
    .cpl_data_len(cpl_data_len));
  guest_driver_model i_guest_driver_model (.clock(clock), .req_ready(req_ready), .desc_ready(desc_ready),
    .req_valid(req_valid), .req_type(req_type), .req_prio(req_prio), .req_sector(req_sector),
    .desc_valid(desc_valid), .desc_len(desc_len), .desc_wr(desc_wr), .desc_last(desc_last));

  // 25 MHz clock
  always #20 clock = ~clock;

  // backend: capture every command on the edge that takes it
  always @(posedge clock) begin
    if (cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
      cmd_count <= cmd_count + 1;
      c_op <= cmd_op;
      c_tag <= cmd_tag;
      c_sector <= cmd_sector;
      c_prio <= cmd_prio;
      c_len <= cmd_len;
      c_cdb <= cmd_cdb_len;
      c_dir <= cmd_dir_in;
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // extra edge after the strobe so a following task never re-assigns it in one step
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask : reg_write

  // read data stand only in the cycle after the strobe
  task automatic reg_expect(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    check(reg_rdata, exp);
  endtask : reg_expect

  task automatic wait_cpl();
    int n;
    n = 0;
    while (cpl_valid !== 1'b1 && n < 12) begin
      @(posedge clock);
      n++;
    end
    check(cpl_valid, 1'b1);
  endtask : wait_cpl

  task automatic wait_cmd(input int prev);
    int n;
    n = 0;
    while (cmd_count == prev && n < 20) begin
      @(posedge clock);
      n++;
    end
    check(cmd_count, prev + 1);
  endtask : wait_cmd

  task automatic done(input logic [TW-1:0] tag, input logic err, input logic [31:0] xfer, input logic [7:0] sn);
    done_valid <= 1'b1;
    done_tag <= tag;
    done_err <= err;
    done_xfer <= xfer;
    done_sense_len <= sn;
    @(posedge clock);
    done_valid <= 1'b0;
    done_xfer <= ~xfer;
    wait_cpl();
  endtask : done

  task automatic t_regs();
    logic [7:0] addrs [6];
    addrs = '{REG_CTRL, REG_IRQ_STATUS, REG_IRQ_CLEAR, REG_IRQ_ENABLE, REG_INFLIGHT, 8'h20};
    foreach (addrs[i]) reg_expect(addrs[i], 32'h0);
    reg_write(REG_IRQ_STATUS, 32'h7);
    reg_expect(REG_IRQ_STATUS, 32'h0);
    reg_write(REG_IRQ_ENABLE, 32'hffff_ffff);
    reg_expect(REG_IRQ_ENABLE, 32'h7);
    $display("test registers finished");
  endtask : t_regs

  task automatic t_write();
    int prev;
    prev = cmd_count;
    i_guest_driver_model.post(TYPE_WRITE, 32'h7, 64'h1234, HDR_DESC_BYTES, 32'h200, 1'b0, 1'b0, 32'h0);
    wait_cmd(prev);
    check(c_op, OP_WRITE);
    check(c_sector, 64'h1234);
    check(c_prio, 32'h7);
    check({c_len, c_dir}, {32'h200, 1'b0});
    done(c_tag, 1'b0, 32'h200, 8'h0);
    check({cpl_status, cpl_residual}, {ST_OK, 32'h0});
    check(irq, 1'b1);
    reg_expect(REG_IRQ_STATUS, 32'h1);
    reg_write(REG_IRQ_CLEAR, 32'h1);
    check(irq, 1'b0);
    $display("test write finished");
  endtask : t_write

  // read into the guest; the backend stalls the command a few cycles first
  task automatic t_read();
    int prev;
    prev = cmd_count;
    cmd_ready <= 1'b0;
    i_guest_driver_model.post(TYPE_READ, 32'h0, 64'h40, HDR_DESC_BYTES, 32'h400, 1'b1, 1'b0, 32'h0);
    repeat (3) @(posedge clock);
    check(cmd_count, prev);
    cmd_ready <= 1'b1;
    wait_cmd(prev);
    check(c_op, OP_READ);
    check({c_len, c_dir, c_sector}, {32'h400, 1'b1, 64'h40});
    done(c_tag, 1'b0, 32'h400, 8'h0);
    check(cpl_status, ST_OK);
    $display("test read finished");
  endtask : t_read

  // flush after a completed read, both codes, big-endian guest
  task automatic t_flush_be();
    int prev;
    reg_write(REG_CTRL, 32'h1);
    for (int i = 0; i < 2; i++) begin
      prev = cmd_count;
      i_guest_driver_model.post(i == 0 ? 32'h0400_0000 : 32'h0500_0000, 32'h0900_0000,
        64'h3412_0000_0000_0000, HDR_DESC_BYTES, 32'h0, 1'b0, 1'b0, 32'h0);
      wait_cmd(prev);
      check(c_op, OP_FLUSH);
      check(c_sector, 64'h1234);
      check(c_prio, 32'h9);
      done(c_tag, 1'b0, 32'h0, 8'h0);
    end
    reg_write(REG_CTRL, 32'h0);
    $display("test flush finished");
  endtask : t_flush_be

  task automatic t_unsupp();
    logic [31:0] types [3];
    int prev;
    types = '{32'h9, TYPE_SCSI, 32'h8000_0000};
    reg_write(REG_IRQ_ENABLE, 32'h0);
    foreach (types[i]) begin
      prev = cmd_count;
      i_guest_driver_model.post(types[i], 32'h0, 64'h0, HDR_DESC_BYTES, 32'h200, 1'b1, 1'b0, 32'h0);
      wait_cpl();
      check({cpl_status, 32'(cmd_count)}, {ST_UNSUPP, 32'(prev)});
    end
    check(irq, 1'b0);
    reg_expect(REG_IRQ_STATUS, 32'h3);
    reg_write(REG_IRQ_ENABLE, 32'h2);
    check(irq, 1'b1);
    reg_write(REG_IRQ_CLEAR, 32'h7);
    check(irq, 1'b0);
    prev = cmd_count;
    i_guest_driver_model.post(TYPE_WRITE, 32'h0, 64'h0, 32'h10, 32'h200, 1'b0, 1'b0, 32'h0);
    wait_cpl();
    check({cpl_status, 32'(cmd_count)}, {ST_IOERR, 32'(prev)});
    $display("test unsupported finished");
  endtask : t_unsupp

  task automatic t_scsi();
    int prev;
    reg_write(REG_CTRL, 32'h4);
    for (int i = 0; i < 2; i++) begin
      prev = cmd_count;
      i_guest_driver_model.post(i == 0 ? TYPE_SCSI : TYPE_SCSI_OUT, 32'h0, 64'h0, HDR_DESC_BYTES, 32'h400,
        1'b1, 1'b1, 32'h6 + 32'(i));
      wait_cmd(prev);
      check(c_op, OP_SCSI);
      check(c_cdb, 32'h6 + 32'(i));
      check({c_len, c_dir}, {32'h400, 1'b1});
      done(c_tag, i == 1, 32'h200, i == 0 ? 8'h12 : 8'hc8);
      check(cpl_residual, 32'h200);
      check(cpl_sense_len, i == 0 ? 8'h12 : 8'h60);
      check({cpl_scsi, cpl_data_len}, {1'b1, 32'h400});
      check(cpl_status, i == 0 ? ST_OK : ST_IOERR);
    end
    reg_write(REG_CTRL, 32'h0);
    $display("test scsi finished");
  endtask : t_scsi

  task automatic t_barrier();
    int prev;
    reg_write(REG_CTRL, 32'h2);
    prev = cmd_count;
    i_guest_driver_model.post(TYPE_WRITE, 32'h0, 64'h8, HDR_DESC_BYTES, 32'h200, 1'b0, 1'b0, 32'h0);
    wait_cmd(prev);
    t_a = c_tag;
    i_guest_driver_model.post(32'h8000_0001, 32'h0, 64'h9, HDR_DESC_BYTES, 32'h200, 1'b0, 1'b0, 32'h0);
    repeat (4) @(posedge clock);
    check(cmd_count, prev + 1);
    reg_expect(REG_INFLIGHT, 32'h1);
    done(t_a, 1'b0, 32'h200, 8'h0);
    wait_cmd(prev + 1);
    check(c_op, OP_WRITE);
    check(c_sector, 64'h9);
    t_a = c_tag;
    i_guest_driver_model.post(TYPE_WRITE, 32'h0, 64'ha, HDR_DESC_BYTES, 32'h200, 1'b0, 1'b0, 32'h0);
    repeat (4) @(posedge clock);
    check(cmd_count, prev + 2);
    done(t_a, 1'b0, 32'h200, 8'h0);
    wait_cmd(prev + 2);
    check(c_sector, 64'ha);
    done(c_tag, 1'b0, 32'h200, 8'h0);
    $display("test barrier finished");
  endtask : t_barrier

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  // watchdog at 8000 cycles, well past the few hundred cycles the tests need
  initial begin
    #(40 * 8000);
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    report_and_stop();
  end

  // main sequence
  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    {reg_wr, reg_rd, done_valid, done_err} = 4'h0;
    {reg_addr, reg_wdata, done_tag, done_xfer, done_sense_len} = '0;
    cmd_ready = 1'b1;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    check({req_ready, cmd_valid, irq}, 3'b100);
    t_regs();
    t_write();
    t_read();
    t_flush_be();
    t_unsupp();
    t_scsi();
    t_barrier();
    report_and_stop();
  end
endmodule : tb_blk_req_parser
